// file: core/anps_pkg.sv
// Purpose: constants and carriers for the negotiation page and status registers
// Assumes: 5-bit management register address, 16-bit data
// Notes:   one package shared by the register bank and its checks
package anps_pkg;
  localparam logic [4:0]  ADDR_BASIC_STATUS_REGISTER  = 5'h01;
  localparam logic [4:0]  ADDR_ADV   = 5'h04;
  localparam logic [4:0]  ADDR_LP    = 5'h05;
  localparam logic [4:0]  ADDR_EXP   = 5'h06;
  localparam logic [4:0]  ADDR_NPTX  = 5'h07;
  localparam logic [4:0]  ADDR_STS   = 5'h10;
  localparam logic [4:0]  ADDR_INTERRUPT_STATUS_REGISTER  = 5'h12;
  localparam logic [4:0]  ADDR_FALSE_CARRIER_COUNTER  = 5'h14;
  localparam logic [4:0]  ADDR_RECEIVE_ERROR_COUNTER  = 5'h15;
  localparam logic [4:0]  ADDR_TENSC = 5'h1a;

  localparam logic [4:0]  ADV_SEL_RST   = 5'h01;
  localparam logic        ADV_BIT_RST   = 1'b0;
  localparam logic        NPTX_MP_RST   = 1'b1;
  localparam logic [10:0] NPTX_CODE_RST = 11'h001;
  localparam logic [15:0] LP_RST        = 16'h0000;
  localparam logic        EXP_LOCAL_PAGE_CAPABLE   = 1'b1;
  // base page bit 12 is reserved and must read zero
  localparam logic [15:0] LP_BASE_MASK  = 16'hefff;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anps_mgmt_t;

  typedef struct packed {
    logic        page_rx;
    logic        page_is_next;
    logic [15:0] page_word;
    logic        lcw_done;
    logic        lcw_tog;
    logic        restart;
    logic        parallel_detect_fault;
    logic        partner_page_capable;
    logic        partner_negotiation_capable;
    logic        lp_rfault;
  } anps_an_t;

  typedef struct packed {
    logic mdix;
    logic rx_err;
    logic fcar;
    logic pol_inv;
    logic raw_sd;
    logic lock;
    logic sd_qual_en;
    logic int_ev;
  } anps_phy_t;

  typedef struct packed {
    logic        adv_np;
    logic        adv_rf;
    logic        adv_asym;
    logic        adv_pause;
    logic [3:0]  adv_tech;
    logic [4:0]  adv_sel;
    logic        np_more;
    logic        np_mp;
    logic        np_comply_ack;
    logic        np_tog;
    logic [10:0] np_code;
    logic [15:0] lp_word;
    logic        lp_next;
    logic        parallel_detect_fault;
    logic        partner_page_capable;
    logic        page_rx;
    logic        partner_negotiation_capable;
    logic        mdix;
    logic        rx_err;
    logic        pol;
    logic        fcar;
    logic        sd_ll;
    logic        lock_ll;
    logic        int_pend;
    logic        rfault;
    logic [15:0] rd_data;
    logic        rd_valid;
  } anps_st_t;
endpackage

// file: core/anps_regs.sv
// Purpose: negotiation pages, expansion, next-page transmit, combined status
// Assumes: management frames decoded outside into one-cycle rd/wr strobes
// Notes:   answers only its own addresses; reads of foreign addresses
//          are watched solely to clear the duplicated flags
//
// Contract
// [RULE1] pause advertise bits 11,10 rw, reset zero
// [RULE2] tech bits strapped rw, bit 9 zero
// [RULE3] selector rw, resets to 00001
// [RULE4] partner register shows received abilities, replaced
// [RULE5] partner ack bit set only by negotiation
// [RULE6] partner base view read-only, selector resets zero
// [RULE7] partner next-page view read-only layout
// [RULE8] expansion bit 4 parallel detect fault
// [RULE9] expansion bits 3,0 partner capabilities
// [RULE10] expansion bit 2 always one
// [RULE11] page received set, cleared by expansion read
// [RULE12] transmit np, mp reset one, comply_ack
// [RULE13] transmit toggle inverts last exchanged toggle
// [RULE14] transmit code rw, resets to null page
// [RULE15] status bit 14 follows crossover state
// [RULE16] bit 13 latches receive error, clears on counter read
// [RULE17] bit 12 polarity, cleared by ten-meg read
// [RULE18] bit 11 latches false carrier, counter read clears
// [RULE19] bits 10,9 latched-low qualified detect, lock
// [RULE20] bit 8 mirrors page received flag
// [RULE21] bit 7 interrupt pending, cleared on read
// [RULE22] bit 6 partner remote fault, basic_status_register read clears
// [RULE23] latched bits hold until their register read
// [RULE24] software renegotiates after advertisement changes
// [RULE25] base layout until next-page exchange happens
`timescale 1ns/1ps
module anps_regs
  import anps_pkg::*;
(
  input  wire logic        clk_in,         // 100 MHz device clock
  input  wire logic        sys_rst_in,     // synchronous reset, active high
  input  wire logic        soft_rst_in,    // software reset pulse
  input  wire logic [3:0]  strap_tech_in,  // tech ability straps, bits 8..5
  input  wire anps_mgmt_t  mgmt_in,        // decoded management access
  input  wire anps_an_t    an_in,          // negotiation engine events
  input  wire anps_phy_t   phy_in,         // link monitor and pcs events
  output logic [15:0]      rd_data_out,    // read data, valid with rd_valid
  output logic             rd_valid_out,   // one-cycle read answer
  output logic [15:0]      adv_word_out,   // advertised base page
  output logic [15:0]      np_word_out     // next page to transmit
);
  anps_st_t st;
  anps_st_t next_st;

  logic rst;
  logic rd_basic_status_register;
  logic rd_exp;
  logic rd_sts;
  logic rd_interrupt_status_register;
  logic rd_false_carrier_counter;
  logic rd_receive_error_counter;
  logic rd_tensc;
  logic wr_adv;
  logic wr_nptx;
  logic sd_qual;

  assign rst      = sys_rst_in | soft_rst_in;
  assign rd_basic_status_register  = mgmt_in.rd && mgmt_in.addr == ADDR_BASIC_STATUS_REGISTER;
  assign rd_exp   = mgmt_in.rd && mgmt_in.addr == ADDR_EXP;
  assign rd_sts   = mgmt_in.rd && mgmt_in.addr == ADDR_STS;
  assign rd_interrupt_status_register  = mgmt_in.rd && mgmt_in.addr == ADDR_INTERRUPT_STATUS_REGISTER;
  assign rd_false_carrier_counter  = mgmt_in.rd && mgmt_in.addr == ADDR_FALSE_CARRIER_COUNTER;
  assign rd_receive_error_counter  = mgmt_in.rd && mgmt_in.addr == ADDR_RECEIVE_ERROR_COUNTER;
  assign rd_tensc = mgmt_in.rd && mgmt_in.addr == ADDR_TENSC;
  assign wr_adv   = mgmt_in.wr && mgmt_in.addr == ADDR_ADV;
  assign wr_nptx  = mgmt_in.wr && mgmt_in.addr == ADDR_NPTX;
  // [RULE19] qualified detect
  assign sd_qual  = phy_in.raw_sd & (phy_in.lock | ~phy_in.sd_qual_en);

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;

    // [RULE1] pause advertise writes
    if (wr_adv) begin
      next_st.adv_np    = mgmt_in.wdata[15];
      next_st.adv_rf    = mgmt_in.wdata[13];
      next_st.adv_asym  = mgmt_in.wdata[11];
      next_st.adv_pause = mgmt_in.wdata[10];
      // [RULE2] bit 9 not stored
      next_st.adv_tech  = mgmt_in.wdata[8:5];
      // [RULE3] selector writable
      next_st.adv_sel   = mgmt_in.wdata[4:0];
    end

    // [RULE12] transmit page fields, bit 14 dropped
    if (wr_nptx) begin
      next_st.np_more = mgmt_in.wdata[15];
      next_st.np_mp   = mgmt_in.wdata[13];
      next_st.np_comply_ack = mgmt_in.wdata[12];
      // [RULE14] code writable
      next_st.np_code = mgmt_in.wdata[10:0];
    end
    // [RULE13] toggle from exchanged word
    if (an_in.lcw_done) begin
      next_st.np_tog = ~an_in.lcw_tog;
    end

    // [RULE25] layout selection
    if (an_in.restart) begin
      next_st.lp_next = 1'b0;
    end
    // [RULE4] partner word replaced
    if (an_in.page_rx) begin
      // [RULE5] ack comes only from received bursts
      if (an_in.page_is_next) begin
        // [RULE7] next-page layout taken whole
        next_st.lp_word = an_in.page_word;
        next_st.lp_next = 1'b1;
      end else begin
        // [RULE6] base layout, reserved bit masked
        next_st.lp_word = an_in.page_word & LP_BASE_MASK;
      end
    end

    // [RULE8] fault follows detector
    next_st.parallel_detect_fault        = an_in.parallel_detect_fault;
    // [RULE9] partner capabilities
    next_st.partner_page_capable = an_in.partner_page_capable;
    next_st.partner_negotiation_capable = an_in.partner_negotiation_capable;
    // [RULE11] set beats read clear
    next_st.page_rx    = an_in.page_rx | (st.page_rx & ~rd_exp);

    // [RULE15] live crossover state
    next_st.mdix     = phy_in.mdix;
    // [RULE16] receive error latch
    next_st.rx_err   = phy_in.rx_err | (st.rx_err & ~rd_receive_error_counter);
    // [RULE17] polarity latch
    next_st.pol      = phy_in.pol_inv | (st.pol & ~rd_tensc);
    // [RULE18] false carrier latch
    next_st.fcar     = phy_in.fcar | (st.fcar & ~rd_false_carrier_counter);
    // [RULE23] latched low: reload on own read, else hold a drop
    if (rd_sts) begin
      next_st.sd_ll   = sd_qual;
      next_st.lock_ll = phy_in.lock;
    end else begin
      next_st.sd_ll   = st.sd_ll & sd_qual;
      next_st.lock_ll = st.lock_ll & phy_in.lock;
    end
    // [RULE21] interrupt pending
    next_st.int_pend = phy_in.int_ev | (st.int_pend & ~rd_interrupt_status_register);
    // [RULE22] partner remote fault
    next_st.rfault   = an_in.lp_rfault | (st.rfault & ~rd_basic_status_register);

    // read answer is taken from the flags before the clear above lands
    if (mgmt_in.rd) begin
      next_st.rd_valid = 1'b1;
      case (mgmt_in.addr)
        ADDR_ADV: begin
          next_st.rd_data = {st.adv_np, 1'b0, st.adv_rf, 1'b0, st.adv_asym,
                             st.adv_pause, 1'b0, st.adv_tech, st.adv_sel};
        end
        ADDR_LP: begin
          // [RULE25] reserved bit hidden while the base layout is shown
          next_st.rd_data = st.lp_next ? st.lp_word : st.lp_word & LP_BASE_MASK;
        end
        ADDR_EXP: begin
          // [RULE10] local page ability fixed
          next_st.rd_data = {11'h000, st.parallel_detect_fault, st.partner_page_capable, EXP_LOCAL_PAGE_CAPABLE,
                             st.page_rx, st.partner_negotiation_capable};
        end
        ADDR_NPTX: begin
          next_st.rd_data = {st.np_more, 1'b0, st.np_mp, st.np_comply_ack,
                             st.np_tog, st.np_code};
        end
        ADDR_STS: begin
          // [RULE20] duplicate of page received
          next_st.rd_data = {1'b0, st.mdix, st.rx_err, st.pol, st.fcar,
                             st.sd_ll, st.lock_ll, st.page_rx, st.int_pend,
                             st.rfault, 6'h00};
        end
        default: begin
          next_st.rd_valid = 1'b0;
          next_st.rd_data  = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      st           <= '0;
      st.adv_np    <= ADV_BIT_RST;
      st.adv_rf    <= ADV_BIT_RST;
      // [RULE1] pause bits clear
      st.adv_asym  <= ADV_BIT_RST;
      st.adv_pause <= ADV_BIT_RST;
      // [RULE2] straps caught at reset, clocked
      st.adv_tech  <= strap_tech_in;
      // [RULE3] ieee selector
      st.adv_sel   <= ADV_SEL_RST;
      // [RULE12] message page default
      st.np_mp     <= NPTX_MP_RST;
      // [RULE14] null message code
      st.np_code   <= NPTX_CODE_RST;
      // [RULE6] partner word clear
      st.lp_word   <= LP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out  = st.rd_data;
  assign rd_valid_out = st.rd_valid;
  assign adv_word_out = {st.adv_np, 1'b0, st.adv_rf, 1'b0, st.adv_asym,
                         st.adv_pause, 1'b0, st.adv_tech, st.adv_sel};
  assign np_word_out  = {st.np_more, 1'b0, st.np_mp, st.np_comply_ack,
                         st.np_tog, st.np_code};

  // checks
  sequence exp_read_s;
    rd_exp && !an_in.page_rx;
  endsequence

  sequence lcw_s;
    an_in.lcw_done;
  endsequence

  sel_reset_val_a: assert property ( // [RULE3]
    @(posedge clk_in) disable iff (rst)
    $fell(sys_rst_in) && !soft_rst_in |-> st.adv_sel == ADV_SEL_RST)
    else $error("selector reset value wrong");

  t4_zero_a: assert property ( // [RULE2]
    @(posedge clk_in) disable iff (rst)
    adv_word_out[9] == 1'b0 && np_word_out[14] == 1'b0)
    else $error("reserved advert bit set");

  local_page_capable_a: assert property ( // [RULE10]
    @(posedge clk_in) disable iff (rst)
    rd_exp |=> rd_valid_out && rd_data_out[2])
    else $error("local page ability not one");

  page_set_a: assert property ( // [RULE11]
    @(posedge clk_in) disable iff (rst)
    an_in.page_rx |=> st.page_rx)
    else $error("page received not set");

  page_clear_a: assert property ( // [RULE11]
    @(posedge clk_in) disable iff (rst)
    exp_read_s |=> !st.page_rx)
    else $error("page received not cleared");

  sts_page_dup_a: assert property ( // [RULE20]
    @(posedge clk_in) disable iff (rst)
    rd_sts && !rd_exp |=> rd_data_out[8] == $past(st.page_rx) &&
                          (st.page_rx || !$past(st.page_rx)))
    else $error("status read disturbed page flag");

  toggle_inv_a: assert property ( // [RULE13]
    @(posedge clk_in) disable iff (rst)
    lcw_s |=> np_word_out[11] == !$past(an_in.lcw_tog))
    else $error("transmit toggle not inverted");

  rx_err_hold_a: assert property ( // [RULE16]
    @(posedge clk_in) disable iff (rst)
    phy_in.rx_err ##1 !rd_receive_error_counter |=> st.rx_err)
    else $error("receive error latch lost");

  sd_low_a: assert property ( // [RULE19]
    @(posedge clk_in) disable iff (rst)
    !phy_in.raw_sd ##1 !rd_sts |=> !st.sd_ll)
    else $error("signal detect not latched low");

  rfault_clr_a: assert property ( // [RULE22]
    @(posedge clk_in) disable iff (rst)
    rd_basic_status_register && !an_in.lp_rfault |=> !st.rfault)
    else $error("remote fault not cleared");

  rfault_set_a: assert property ( // [RULE22]
    @(posedge clk_in) disable iff (rst)
    an_in.lp_rfault |=> st.rfault)
    else $error("remote fault not latched");

  pause_reset_a: assert property ( // [RULE1]
    @(posedge clk_in) disable iff (rst)
    $fell(sys_rst_in) && !soft_rst_in |-> adv_word_out[11:10] == 2'b00)
    else $error("pause advertise reset value wrong");

  strap_reset_a: assert property ( // [RULE2]
    @(posedge clk_in) disable iff (rst)
    $fell(sys_rst_in) && !soft_rst_in |-> adv_word_out[8:5] == $past(strap_tech_in))
    else $error("strapped abilities not taken at reset");

  adv_write_a: assert property ( // [RULE1]
    @(posedge clk_in) disable iff (rst)
    wr_adv |=> adv_word_out == ($past(mgmt_in.wdata) & 16'hadff))
    else $error("advertisement write not stored");

  nptx_write_a: assert property ( // [RULE12]
    @(posedge clk_in) disable iff (rst)
    wr_nptx |=> (np_word_out & 16'hb7ff) == ($past(mgmt_in.wdata) & 16'hb7ff))
    else $error("next page write not stored");

  code_reset_a: assert property ( // [RULE14]
    @(posedge clk_in) disable iff (rst)
    $fell(sys_rst_in) && !soft_rst_in |->
      np_word_out[13] && np_word_out[10:0] == NPTX_CODE_RST)
    else $error("null message page not restored");

  lp_hold_a: assert property ( // [RULE5]
    @(posedge clk_in) disable iff (rst)
    !an_in.page_rx |=> $stable(st.lp_word))
    else $error("partner word changed without a page");

  lp_next_take_a: assert property ( // [RULE7]
    @(posedge clk_in) disable iff (rst)
    an_in.page_rx && an_in.page_is_next |=>
      st.lp_word == $past(an_in.page_word) && st.lp_next)
    else $error("next page not taken whole");

  lp_base_take_a: assert property ( // [RULE4]
    @(posedge clk_in) disable iff (rst)
    an_in.page_rx && !an_in.page_is_next |=>
      st.lp_word == ($past(an_in.page_word) & LP_BASE_MASK))
    else $error("base page not taken");

  lp_base_view_a: assert property ( // [RULE25]
    @(posedge clk_in) disable iff (rst)
    mgmt_in.rd && mgmt_in.addr == ADDR_LP && !st.lp_next |=> !rd_data_out[12])
    else $error("reserved bit shown in base layout");

  pdf_follow_a: assert property ( // [RULE8]
    @(posedge clk_in) disable iff (rst)
    1'b1 |=> st.parallel_detect_fault == $past(an_in.parallel_detect_fault))
    else $error("parallel detect fault not followed");

  partner_caps_a: assert property ( // [RULE9]
    @(posedge clk_in) disable iff (rst)
    1'b1 |=> st.partner_page_capable == $past(an_in.partner_page_capable) &&
             st.partner_negotiation_capable == $past(an_in.partner_negotiation_capable))
    else $error("partner capabilities not followed");

  mdix_follow_a: assert property ( // [RULE15]
    @(posedge clk_in) disable iff (rst)
    1'b1 |=> st.mdix == $past(phy_in.mdix))
    else $error("crossover state not followed");

  pol_hold_a: assert property ( // [RULE17]
    @(posedge clk_in) disable iff (rst)
    st.pol && !rd_tensc |=> st.pol)
    else $error("polarity flag lost without its read");

  pol_clear_a: assert property ( // [RULE17]
    @(posedge clk_in) disable iff (rst)
    rd_tensc && !phy_in.pol_inv |=> !st.pol)
    else $error("polarity flag not cleared");

  fcar_hold_a: assert property ( // [RULE18]
    @(posedge clk_in) disable iff (rst)
    phy_in.fcar ##1 !rd_false_carrier_counter |=> st.fcar)
    else $error("false carrier latch lost");

  int_clear_a: assert property ( // [RULE21]
    @(posedge clk_in) disable iff (rst)
    rd_interrupt_status_register && !phy_in.int_ev |=> !st.int_pend)
    else $error("interrupt pending not cleared");
endmodule

// file: dv/anps_mgmt_model.sv
// Purpose: station management side, issues decoded reads and writes
// Assumes: one request at a time, launched on the falling edge
// Notes:   idle fields carry inverted stale values so nothing leans on them
`timescale 1ns/1ps
module anps_mgmt_model
  import anps_pkg::*;
(
  input  wire logic clk_in,   // device clock
  output anps_mgmt_t mgmt_out // request toward the bank
);
  initial begin
    mgmt_out = '0;
  end
  task automatic req(input logic r, input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    mgmt_out <= '{rd: r, wr: w, addr: a, wdata: d};
    @(negedge clk_in);
    mgmt_out <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// file: dv/anps_regs_tb.sv
// Purpose: self-checking bench for the negotiation page and status bank
// Assumes: reads answered one cycle later, foreign addresses never answered
// Notes:   expected read words queued by the driver, popped by the monitor
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, x); end end
module anps_regs_tb
  import anps_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        soft_rst_in = 1'b0;
  logic [3:0]  strap_tech_in = 4'h0;
  anps_mgmt_t  mgmt_in;
  anps_an_t    an_in = '0;
  anps_phy_t   phy_in = '0;
  logic [15:0] rd_data_out, adv_word_out, np_word_out, got_e, w, s, e, p;
  logic        rd_valid_out;
  logic [15:0] exp_q[$];
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [4:0]  clr_a[5] = '{ADDR_RECEIVE_ERROR_COUNTER, ADDR_FALSE_CARRIER_COUNTER, ADDR_TENSC, ADDR_INTERRUPT_STATUS_REGISTER, ADDR_BASIC_STATUS_REGISTER};
  logic [15:0] bit_m[5] = '{16'h2000, 16'h0800, 16'h1000, 16'h0080, 16'h0040};
  anps_phy_t   ev_p[4] = '{'{rx_err: 1'b1, default: 1'b0}, '{fcar: 1'b1, default: 1'b0},
                           '{pol_inv: 1'b1, default: 1'b0}, '{int_ev: 1'b1, default: 1'b0}};

  always #5 clk_in = ~clk_in;

  anps_regs dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
    .strap_tech_in(strap_tech_in), .mgmt_in(mgmt_in), .an_in(an_in), .phy_in(phy_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .adv_word_out(adv_word_out),
    .np_word_out(np_word_out));
  anps_mgmt_model mdl_u (.clk_in(clk_in), .mgmt_out(mgmt_in));

  task automatic report_and_stop();
    if (exp_q.size() != 0) fails++;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // answers settle before the falling edge; an unexpected one is a mismatch
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    if (rd_valid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR t=%0t got=%h exp=none", $time, rd_data_out);
      end else begin
        got_e = exp_q.pop_front();
        `CHK(rd_data_out, got_e)
      end
    end
    if (cyc == 4000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    if (a inside {ADDR_ADV, ADDR_LP, ADDR_EXP, ADDR_NPTX, ADDR_STS}) exp_q.push_back(x);
    mdl_u.req(1'b1, 1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mdl_u.req(1'b0, 1'b1, a, d);
  endtask
  // one-cycle excursion; xor lets the same call drop a level input too
  task automatic phy_pulse(input anps_phy_t v);
    @(negedge clk_in);
    phy_in <= phy_in ^ v;
    @(negedge clk_in);
    phy_in <= phy_in ^ v;
  endtask
  task automatic an_pulse(input anps_an_t v);
    @(negedge clk_in);
    an_in <= an_in ^ v;
    @(negedge clk_in);
    an_in <= an_in ^ v;
  endtask

  initial begin
    void'($urandom(32'ha05b3af3));
    strap_tech_in = 4'($urandom());
    repeat (4) @(negedge clk_in);
    sys_rst_in <= 1'b0;
    rd(ADDR_ADV, {7'h00, strap_tech_in, 5'h01});
    rd(ADDR_LP, 16'h0000);
    rd(ADDR_EXP, 16'h0004);
    rd(ADDR_NPTX, 16'h2001);
    rd(5'h1f, 16'h0000);
    $display("test reset values done");
    phy_in <= '{raw_sd: 1'b1, lock: 1'b1, sd_qual_en: 1'b1, default: 1'b0};
    rd(ADDR_STS, 16'h0000);
    for (int q = 1; q >= 0; q--) begin
      phy_in.sd_qual_en <= q[0];
      rd(ADDR_STS, 16'h0600);
      phy_pulse('{lock: 1'b1, default: 1'b0});
      rd(ADDR_STS, q ? 16'h0000 : 16'h0400);
    end
    phy_in.mdix <= 1'b1;
    s = 16'h4600;
    rd(ADDR_STS, s);
    $display("test latched low done");
    for (int i = 0; i < 5; i++) begin
      if (i < 4) phy_pulse(ev_p[i]);
      else an_pulse('{lp_rfault: 1'b1, default: '0});
      rd(ADDR_STS, s | bit_m[i]);
      rd(ADDR_STS, s | bit_m[i]);
      rd(clr_a[i], 16'h0000);
      rd(ADDR_STS, s);
    end
    $display("test latched high done");
    an_in.parallel_detect_fault <= 1'b1;
    an_in.partner_page_capable <= 1'b1;
    an_in.partner_negotiation_capable <= 1'b1;
    e = 16'h001d;
    rd(ADDR_EXP, e);
    for (int k = 0; k < 3; k++) begin
      w = 16'($urandom()) | 16'h1000;
      if (k == 2) an_pulse('{restart: 1'b1, default: '0});
      an_pulse('{page_rx: 1'b1, page_is_next: (k == 1), page_word: w, default: '0});
      p = (k == 1) ? w : w & 16'hefff;
      rd(ADDR_STS, s | 16'h0100);
      rd(ADDR_STS, s | 16'h0100);
      rd(ADDR_LP, p);
      rd(ADDR_EXP, e | 16'h0002);
      rd(ADDR_EXP, e);
      rd(ADDR_STS, s);
    end
    $display("test pages done");
    for (int j = 0; j < 2; j++) begin
      w = j ? 16'hffff : 16'($urandom());
      wr(ADDR_ADV, w);
      an_pulse('{restart: 1'b1, default: '0});
      rd(ADDR_ADV, w & 16'hadff);
      `CHK(adv_word_out, w & 16'hadff)
      wr(ADDR_NPTX, w);
      rd(ADDR_NPTX, w & 16'hb7ff);
      `CHK(np_word_out, w & 16'hb7ff)
    end
    wr(ADDR_LP, 16'hffff);
    wr(ADDR_EXP, 16'hffff);
    wr(ADDR_STS, 16'hffff);
    rd(ADDR_LP, p);
    rd(ADDR_EXP, e);
    rd(ADDR_STS, s);
    for (int t = 0; t < 2; t++) begin
      an_pulse('{lcw_done: 1'b1, lcw_tog: t[0], default: '0});
      rd(ADDR_NPTX, 16'hb7ff | {4'h0, ~t[0], 11'h000});
    end
    $display("test writes done");
    @(negedge clk_in);
    soft_rst_in <= 1'b1;
    strap_tech_in <= 4'($urandom());
    @(negedge clk_in);
    soft_rst_in <= 1'b0;
    rd(ADDR_ADV, {7'h00, strap_tech_in, 5'h01});
    rd(ADDR_NPTX, 16'h2001);
    rd(ADDR_LP, 16'h0000);
    rd(ADDR_STS, 16'h4000);
    $display("test soft reset done");
    repeat (3) @(negedge clk_in);
    report_and_stop();
  end
endmodule
